// >>> logic/spi_port.v
// Purpose: serial port with configuration/status, master and slave link timing
// Assumes: link pins are asynchronous to ref_clk and are synchronised here
// Notes: slave timing figures are counted from the synchronised pin levels
`timescale 1ns/1ps
`include "spi_port_defines.vh"
`default_nettype none
module spi_port (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] sfrAddr,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrWdata,
  output reg [7:0] sfrRdata,
  input wire sckIn,
  output reg sckOut,
  output wire sckOe,
  input wire mosiIn,
  output wire mosiOut,
  output wire mosiOe,
  input wire misoIn,
  output wire misoOut,
  output wire misoOe,
  input wire slaveSelectN
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit order: 3 sck, 2 mosi, 1 miso, 0 select
  reg [3:0] pinS1;
  reg [3:0] pinS2;
  reg [3:0] pinS3;
  wire [3:0] pinRaw = {sckIn, mosiIn, misoIn, slaveSelectN};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gSync
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pinS1[gi] <= 1'b1;
          pinS2[gi] <= 1'b1;
          pinS3[gi] <= 1'b1;
        end
        else
        begin
          pinS1[gi] <= pinRaw[gi];
          pinS2[gi] <= pinS1[gi];
          pinS3[gi] <= pinS2[gi];
        end
      end
    end
  endgenerate
  // ****************************************
  // State
  // ****************************************
  reg enable;
  reg master;
  reg cpha;
  reg cpol;
  reg [7:0] clockRate;
  reg doneFlag;
  reg wcolFlag;
  reg ovrFlag;
  reg [7:0] txBuf;
  reg txFull;
  reg selected;
  reg running;
  reg [4:0] edgeCnt;
  reg [7:0] divCnt;
  reg [7:0] txShift;
  reg [7:0] rxShift;
  reg outBit;
  reg shiftLoaded;
  reg [2:0] bitCnt;
  reg [2:0] slhCnt;
  reg [7:0] rxMem [0:1];
  reg wp;
  reg rp;
  reg [1:0] rxCnt;
  // ****************************************
  // Decode and link events
  // ****************************************
  wire wrCfg = sfrWrite && (sfrAddr == `OFS_CFG);
  wire wrCtl = sfrWrite && (sfrAddr == `OFS_CTRL);
  wire wrDat = sfrWrite && (sfrAddr == `OFS_DATA);
  wire wrRate = sfrWrite && (sfrAddr == `OFS_RATE);
  wire rdDat = sfrRead && (sfrAddr == `OFS_DATA);
  wire rxEmpty = (rxCnt == 2'h0);
  wire rxFull = (rxCnt == `FIFO_FULL);
  wire slaveOn = enable && !master;
  wire sckEdge = pinS2[3] ^ pinS3[3];
  wire lead = sckEdge && (pinS2[3] != cpol);
  // Sample edge is the leading edge unless second-edge phase is chosen
  wire sampleE = sckEdge && (lead ^ cpha);
  wire shiftE = sckEdge && !(lead ^ cpha);
  wire selFall = pinS3[0] && !pinS2[0];
  wire tick = (divCnt == 8'h00);
  wire masterSample = running && tick && (edgeCnt < `LAST_EDGE) && (edgeCnt[0] == cpha);
  wire masterShift = running && tick && (edgeCnt < `LAST_EDGE) && (edgeCnt[0] != cpha);
  wire busy = running || (slaveOn && (bitCnt != 3'h0));
  // Master takes the pin two clocks before its edge; rates zero and one outrun the synchroniser
  wire [7:0] nextRx = {rxShift[6:0], master ? pinS2[1] : pinS2[2]};
  wire slavePush = slaveOn && !pinS2[0] && sampleE && (bitCnt == `LAST_BIT);
  wire masterPush = running && tick && (edgeCnt == `LAST_EDGE);
  wire rxPop = rdDat && !rxEmpty;
  wire [7:0] cfgRead = {busy, master, cpha, cpol, selected, pinS2[0],
    master || !shiftLoaded, rxEmpty};
  wire [7:0] ctlRead = {doneFlag, wcolFlag, 1'b0, ovrFlag, 2'b00, !txFull, enable};
  // ****************************************
  // Pin drive
  // ****************************************
  assign sckOe = enable && master;
  assign mosiOe = enable && master;
  assign mosiOut = outBit;
  // Driven from the synchronised select so release and drive stay under four clocks
  assign misoOe = slaveOn && !pinS2[0];
  assign misoOut = outBit;
  // ****************************************
  // Register read
  // ****************************************
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfrRdata <= `BYTE_RST;
    else if (sfrRead)
    begin
      case (sfrAddr)
        `OFS_CFG: sfrRdata <= cfgRead;
        `OFS_CTRL: sfrRdata <= ctlRead;
        `OFS_DATA: sfrRdata <= rxEmpty ? `BYTE_RST : rxMem[rp];
        `OFS_RATE: sfrRdata <= clockRate;
        default: sfrRdata <= `BYTE_RST;
      endcase
    end
  end
  // ****************************************
  // Registers, engine and receive buffer
  // ****************************************
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable <= 1'b0;
      master <= 1'b0;
      cpha <= 1'b0;
      cpol <= 1'b0;
      clockRate <= `RATE_RST;
      doneFlag <= 1'b0;
      wcolFlag <= 1'b0;
      ovrFlag <= 1'b0;
      txBuf <= `BYTE_RST;
      txFull <= 1'b0;
      selected <= 1'b0;
      running <= 1'b0;
      edgeCnt <= 5'h00;
      divCnt <= 8'h00;
      txShift <= `BYTE_RST;
      rxShift <= `BYTE_RST;
      outBit <= 1'b0;
      shiftLoaded <= 1'b0;
      bitCnt <= 3'h0;
      slhCnt <= 3'h0;
      rxMem[0] <= `BYTE_RST;
      rxMem[1] <= `BYTE_RST;
      wp <= 1'b0;
      rp <= 1'b0;
      rxCnt <= 2'h0;
      sckOut <= 1'b0;
    end
    else
    begin
      // Software writes first so hardware sets below win
      if (wrCfg)
      begin
        master <= sfrWdata[`CFG_MASTER];
        cpha <= sfrWdata[`CFG_CPHA];
        cpol <= sfrWdata[`CFG_CPOL];
      end
      if (wrCtl)
      begin
        doneFlag <= sfrWdata[`CTL_DONE];
        wcolFlag <= sfrWdata[`CTL_WCOL];
        ovrFlag <= sfrWdata[`CTL_OVR];
        enable <= sfrWdata[`CTL_EN];
      end
      if (wrRate)
        clockRate <= sfrWdata;
      if (wrDat)
      begin
        if (txFull)
          wcolFlag <= 1'b1;
        else
        begin
          txBuf <= sfrWdata;
          txFull <= 1'b1;
        end
      end
      // Two equal synchronised samples before the status flag follows
      if (pinS2[0] == pinS3[0])
        selected <= !pinS2[0];
      if (!running)
        sckOut <= wrCfg ? sfrWdata[`CFG_CPOL] : cpol;
      // Master engine; stalls while the receive buffer cannot take a byte
      if (enable && master)
      begin
        if (!running)
        begin
          if (txFull && !wrDat && !rxFull && !masterPush)
          begin
            running <= 1'b1;
            edgeCnt <= 5'h00;
            divCnt <= clockRate;
            txShift <= txBuf;
            outBit <= txBuf[7];
            txFull <= 1'b0;
          end
        end
        else if (tick)
        begin
          divCnt <= clockRate;
          if (edgeCnt == `LAST_EDGE)
            running <= 1'b0;
          else
          begin
            sckOut <= !sckOut;
            edgeCnt <= edgeCnt + 5'h01;
          end
        end
        else
          divCnt <= divCnt - 8'h01;
        if (masterSample)
          rxShift <= nextRx;
        if (masterShift)
        begin
          outBit <= cpha ? txShift[7] : txShift[6];
          txShift <= {txShift[6:0], 1'b0};
        end
      end
      else
        running <= 1'b0;
      // Slave engine
      if (!slaveOn)
      begin
        bitCnt <= 3'h0;
        slhCnt <= 3'h0;
      end
      else if (selFall)
      begin
        bitCnt <= 3'h0;
        outBit <= txFull ? txBuf[7] : 1'b0;
        txShift <= txFull ? txBuf : `BYTE_RST;
        shiftLoaded <= txFull;
        if (txFull)
          txFull <= 1'b0;
      end
      else if (!pinS2[0])
      begin
        if (sampleE)
        begin
          rxShift <= nextRx;
          bitCnt <= bitCnt + 3'h1;
          if (bitCnt == `LAST_BIT)
          begin
            shiftLoaded <= 1'b0;
            if (cpha)
              slhCnt <= `SLH_WAIT;
          end
        end
        if (shiftE)
        begin
          if (!cpha && bitCnt == 3'h0)
          begin
            outBit <= txFull ? txBuf[7] : 1'b0;
            txShift <= txFull ? txBuf : `BYTE_RST;
            shiftLoaded <= txFull;
            if (txFull)
              txFull <= 1'b0;
          end
          else
          begin
            outBit <= cpha ? txShift[7] : txShift[6];
            txShift <= {txShift[6:0], 1'b0};
          end
        end
        if (slhCnt != 3'h0)
        begin
          slhCnt <= slhCnt - 3'h1;
          if (slhCnt == 3'h1)
          begin
            outBit <= txFull ? txBuf[7] : 1'b0;
            txShift <= txFull ? txBuf : `BYTE_RST;
            shiftLoaded <= txFull;
            if (txFull)
              txFull <= 1'b0;
          end
        end
      end
      // Receive buffer, two entries
      if (rxPop)
        rp <= !rp;
      if (masterPush || slavePush)
      begin
        doneFlag <= 1'b1;
        if (rxFull && !rxPop)
          ovrFlag <= 1'b1;
        else
        begin
          rxMem[wp] <= masterPush ? rxShift : nextRx;
          wp <= !wp;
        end
      end
      if ((masterPush || slavePush) && !(rxFull && !rxPop) && !rxPop)
        rxCnt <= rxCnt + 2'h1;
      else if (rxPop && !(masterPush || slavePush))
        rxCnt <= rxCnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> logic/spi_port_defines.vh
// Purpose: constants for the serial port register block
// Assumes: 8-bit special function register bus
// Notes: offsets other than configuration are arbitrary placements
`ifndef SPI_PORT_DEFINES_VH
`define SPI_PORT_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CFG 8'hA1
`define OFS_CTRL 8'hF8
`define OFS_DATA 8'hA3
`define OFS_RATE 8'hA2
// ****************************************
// Configuration fields
// ****************************************
`define CFG_BUSY 7
`define CFG_MASTER 6
`define CFG_CPHA 5
`define CFG_CPOL 4
`define CFG_SEL 3
`define CFG_RAW 2
`define CFG_SHIFT_REGISTER_EMPTY_FLAG 1
`define CFG_RECEIVE_BUFFER_EMPTY_FLAG 0
// ****************************************
// Control fields
// ****************************************
`define CTL_DONE 7
`define CTL_WCOL 6
`define CTL_OVR 4
`define CTL_TXBMT 1
`define CTL_EN 0
// ****************************************
// Reset values and counts
// ****************************************
`define RATE_RST 8'h00
`define BYTE_RST 8'h00
`define LAST_EDGE 5'h10
`define LAST_BIT 3'h7
`define SLH_WAIT 3'h4
`define FIFO_FULL 2'h2
`define PIN_RST 4'hF
`endif

// >>> verification/spi_port_asserts.sv
// Purpose: port-level checks of the serial port
// Assumes: registers change only through the register strobes
// Notes: shadows the written fields to know role and levels
`timescale 1ns/1ps
`include "spi_port_defines.vh"
`default_nettype none
module spi_port_asserts (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] sfrAddr,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrWdata,
  input wire [7:0] sfrRdata,
  input wire sckIn,
  input wire sckOut,
  input wire sckOe,
  input wire mosiIn,
  input wire mosiOut,
  input wire mosiOe,
  input wire misoIn,
  input wire misoOut,
  input wire misoOe,
  input wire slaveSelectN
);
  // ********
  // Shadow state
  // ********
  reg mst, pha, pol, en;
  reg [7:0] rate;
  reg [7:0] hc;
  wire cfgRd = sfrRead && sfrAddr == `OFS_CFG;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      {mst, pha, pol, en} <= 4'h0;
      rate <= `RATE_RST;
      hc <= 8'h00;
    end
    else
    begin
      if (sfrWrite && sfrAddr == `OFS_CFG)
        {mst, pha, pol} <= sfrWdata[6:4];
      if (sfrWrite && sfrAddr == `OFS_CTRL)
        en <= sfrWdata[0];
      if (sfrWrite && sfrAddr == `OFS_RATE)
        rate <= sfrWdata;
      // Saturates so a long idle never wraps into a short phase
      hc <= $changed(sckOut) ? 8'h00 : hc + {7'h00, hc != 8'hFF};
    end
  // ********
  // Properties
  // ********
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence selFall;
    $fell(slaveSelectN) && en && !mst;
  endsequence
  sequence selRise;
    $rose(slaveSelectN);
  endsequence
  AST_MASTER_PINS:
    assert property (sckOe |-> mosiOe && !misoOe) else $error("master enables wrong");
  AST_MISO_ON:
    assert property (selFall |-> ##[1:4] misoOe) else $error("miso not driven in time");
  AST_MISO_OFF:
    assert property (selRise |-> ##[1:4] !misoOe) else $error("miso not released");
  AST_IDLE_LEVEL:
    assert property ($rose(sckOe) |-> sckOut == pol) else $error("idle clock level");
  AST_HALF_PERIOD:
    assert property (sckOe && $changed(sckOut) |-> hc >= rate) else $error("clock phase short");
  AST_UNMAPPED:
    assert property (sfrRead && !(sfrAddr inside {`OFS_CFG, `OFS_CTRL, `OFS_DATA, `OFS_RATE})
      |=> sfrRdata == 8'h00) else $error("unmapped read not zero");
  AST_CFG_FIELDS:
    assert property (cfgRd |=> sfrRdata[6:4] == {mst, pha, pol}) else $error("cfg fields");
  AST_BUSY_MID:
    assert property (cfgRd && sckOe && sckOut != pol |=> sfrRdata[7]) else $error("busy low");
endmodule
bind spi_port spi_port_asserts chk (.ref_clk(ref_clk), .rst_n(rst_n), .sfrAddr(sfrAddr),
  .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut),
  .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe),
  .slaveSelectN(slaveSelectN));
`default_nettype wire

// >>> verification/spi_far_slave.sv
// Purpose: far-side serial slave for master runs
// Assumes: three-wire link, loaded before each byte
// Notes: spent bits refill inverted so stale data shows
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic load,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [8:0] sh = 9'h000;
  assign miso = sh[8];
  initial rxByte = 8'h00;
  always @(posedge load)
    sh = pha ? {1'b0, txByte} : {txByte, 1'b0};
  always @(sck)
    if ((sck != pol) ^ pha)
      rxByte = {rxByte[6:0], mosi};
    else
      sh = {sh[7:0], ~sh[0]};
endmodule
`default_nettype wire

// >>> verification/spi_port_tb.sv
// Purpose: register-level bench for the serial port
// Assumes: bench acts as link master in slave runs
// Notes: link clock period 400 ns in both roles
`timescale 1ns/1ps
`include "spi_port_defines.vh"
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module spi_port_tb;
  logic ref_clk = 0, rst_n = 0, sfrWrite = 0, sfrRead = 0;
  logic tbSck = 0, tbMosi = 0, ssn = 1, load = 0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, v, got, b, mTx = 8'h00;
  logic [1:0] md = 2'h0;
  int n_fail = 0, num_checks = 0, m;
  wire [7:0] sfrRdata, rxByte;
  wire sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, mMiso;
  wire sckW = sckOe ? sckOut : tbSck;
  wire mosiW = mosiOe ? mosiOut : tbMosi;
  spi_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sckIn(sckW),
    .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(mMiso), .misoOut(misoOut), .misoOe(misoOe), .slaveSelectN(ssn));
  spi_far_slave far (.sck(sckW), .mosi(mosiW), .pol(md[0]), .pha(md[1]), .load(load),
    .txByte(mTx), .miso(mMiso), .rxByte(rxByte));
  initial forever #25 ref_clk = ~ref_clk;
  // ********
  // Access tasks
  // ********
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge ref_clk);
    sfrWrite <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge ref_clk);
    sfrRead <= 1'b0;
    #1 d = sfrRdata;
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_done;
    int k;
    v = 8'h00;
    for (k = 0; k < 400 && v[7] !== 1'b1; k++)
      rd(`OFS_CTRL, v);
    if (v[7] !== 1'b1)
    begin
      n_fail++;
      wrap_up;
    end
    wr(`OFS_CTRL, 8'h01);
  endtask
  task master_byte(input [7:0] t, input [7:0] d);
    // Idle clock level settles before the model loads
    @(posedge ref_clk);
    mTx = t;
    load = 1'b1;
    #1 load = 1'b0;
    wr(`OFS_DATA, d);
  endtask
  // Clock runs only inside frames, off the system clock's phase
  task sx(input [7:0] o, output [7:0] i, input p);
    int k;
    i = 8'h00;
    @(posedge ref_clk);
    #7 ssn = 1'b0;
    #300;
    for (k = 7; k >= 0; k--)
    begin
      tbSck = p;
      tbMosi = o[k];
      #200 tbSck = ~p;
      i = {i[6:0], misoOe ? misoOut : ~i[0]};
      #200 tbSck = 1'b0;
    end
    #300 ssn = 1'b1;
    #300;
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`OFS_CFG, v);
    `CHK("cfg rst", 8'h07, v)
    rd(`OFS_CTRL, v);
    `CHK("ctl rst", 8'h02, v)
    rd(`OFS_RATE, v);
    `CHK("rate rst", `RATE_RST, v)
    rd(8'h55, v);
    `CHK("unmapped", 8'h00, v)
    wr(`OFS_CFG, 8'hBF);
    rd(`OFS_CFG, v);
    `CHK("cfg ro", 8'h37, v)
    wr(`OFS_RATE, 8'h03);
    wr(`OFS_CTRL, 8'h01);
    for (m = 0; m < 4; m++)
    begin
      md = m[1:0];
      b = 8'h3A + m[7:0];
      wr(`OFS_CFG, {2'b01, md, 4'h0});
      master_byte(8'hC5 ^ m[7:0], b);
      rd(`OFS_CFG, v);
      `CHK("busy", 1'b1, v[7])
      repeat (2) @(posedge ref_clk);
      rd(`OFS_CFG, v);
      `CHK("busy mid", 1'b1, v[7])
      wait_done;
      rd(`OFS_DATA, v);
      `CHK("master rx", mTx, v)
      `CHK("far rx", b, rxByte)
      rd(`OFS_CFG, v);
      `CHK("idle", 8'h47 | {2'h0, md, 4'h0}, v)
    end
    md = 2'h0;
    wr(`OFS_CFG, 8'h40);
    for (m = 0; m < 3; m++)
    begin
      master_byte(8'h60 + m[7:0], 8'h11);
      if (m < 2)
        wait_done;
    end
    repeat (100) @(posedge ref_clk);
    rd(`OFS_CTRL, v);
    `CHK("stall", 1'b0, v[7])
    rd(`OFS_DATA, v);
    `CHK("buf0", 8'h60, v)
    rd(`OFS_DATA, v);
    `CHK("buf1", 8'h61, v)
    wait_done;
    rd(`OFS_DATA, v);
    `CHK("buf2", 8'h62, v)
    for (m = 0; m < 2; m++)
    begin
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_CFG, {2'h0, m[0], 5'h00});
      wr(`OFS_CTRL, 8'h01);
      wr(`OFS_DATA, 8'hA5 ^ m[7:0]);
      sx(8'h3C + m[7:0], got, m[0]);
      wait_done;
      `CHK("slave out", 8'hA5 ^ m[7:0], got)
      rd(`OFS_DATA, v);
      `CHK("slave in", 8'h3C + m[7:0], v)
    end
    wrap_up;
  end
endmodule
`default_nettype wire
